// ### rtl/pfd_defines.svh
// timing, width, field and reset constants of the predriver logic
`ifndef PFD_DEFINES_SVH
`define PFD_DEFINES_SVH
`define PFD_NCH          4
`define PFD_CLK_NS       40
`define PFD_DEGLITCH_NS  10000
`define PFD_DEGLITCH_CYC ((`PFD_DEGLITCH_NS + `PFD_CLK_NS - 1) / `PFD_CLK_NS)
`define PFD_PWM_ON_NS    4000
`define PFD_PWM_ON_CYC   ((`PFD_PWM_ON_NS + `PFD_CLK_NS - 1) / `PFD_CLK_NS)
`define PFD_PWM_PER_NS   80000
`define PFD_PWM_PER_CYC  (`PFD_PWM_PER_NS / `PFD_CLK_NS)
`define PFD_CTRL_RST     4'h0
`define PFD_FAULT_RST    4'h0
`define PFD_SYNC_W       12
`define PFD_SYNC_RST     12'h800
`define PFD_SY_CS        11
`define PFD_SY_REF       10
`define PFD_SY_OV        9
`define PFD_SY_UV        8
`define PFD_SY_DIR       4
`define PFD_SY_SNS       0
`endif

// ### rtl/pfd_pkg.sv
// types shared by the predriver logic
`default_nettype none
package pfd_pkg;
  typedef enum logic [1:0] {
    PFD_SHUTDOWN = 2'b01,
    PFD_PWM      = 2'b10
  } pfd_variant_t;
  typedef enum logic [2:0] {
    PFD_CH_RUN  = 3'b001,
    PFD_CH_SHUT = 3'b010,
    PFD_CH_PWM  = 3'b100
  } pfd_chst_t;
endpackage
`default_nettype wire

// ### rtl/pfd_link_if.sv
// words passed between the core clock domain and the serial clock domain
`default_nettype none
interface pfd_link_if;
  logic [3:0] fault_word;
  logic [3:0] shift_word;
  modport core (output fault_word, input shift_word);
  modport link (input fault_word, output shift_word);
endinterface
`default_nettype wire

// ### rtl/pfd_chan.sv
// one gate channel: short deglitch, shutdown or pwm fallback, load faults
`default_nettype none
`include "pfd_defines.svh"
module pfd_chan #(
  parameter int unsigned DEG_CYC  = `PFD_DEGLITCH_CYC,
  parameter int unsigned PWM_ON   = `PFD_PWM_ON_CYC,
  parameter int unsigned PWM_PER  = `PFD_PWM_PER_CYC,
  parameter bit          PWM_MODE = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cmd,
  input  wire logic sense,
  input  wire logic batt,
  output logic      gate,
  output logic      short_flt,
  output logic      open_flt
);
  localparam int unsigned CW = $clog2(DEG_CYC > PWM_PER ? DEG_CYC : PWM_PER) + 1;
  localparam logic [CW-1:0] DEG_LAST = CW'(DEG_CYC - 1);
  localparam logic [CW-1:0] ON_CNT   = CW'(PWM_ON);
  localparam logic [CW-1:0] ON_LAST  = CW'(PWM_ON - 1);
  localparam logic [CW-1:0] PER_LAST = CW'(PWM_PER - 1);
  pfd_pkg::pfd_chst_t st_reg;
  pfd_pkg::pfd_chst_t st_next;
  logic [CW-1:0]      cnt_reg;
  logic [CW-1:0]      cnt_next;

  // ----------------------------------------------------------------
  // channel state and shared counter
  // ----------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    cnt_next = '0;
    gate     = 1'b0;
    case (st_reg)
      pfd_pkg::PFD_CH_RUN: begin
        gate = cmd & ~batt; // R20
        if (gate && sense) begin // R15
          cnt_next = cnt_reg + 1'b1; // R19
          if (cnt_reg == DEG_LAST) begin // R24
            cnt_next = '0;
            st_next  = PWM_MODE ? pfd_pkg::PFD_CH_PWM : pfd_pkg::PFD_CH_SHUT;
          end
        end
      end
      pfd_pkg::PFD_CH_SHUT: begin
        if (!cmd || batt) begin // R17
          st_next = pfd_pkg::PFD_CH_RUN;
        end
      end
      pfd_pkg::PFD_CH_PWM: begin
        gate     = (cnt_reg < ON_CNT) & ~batt; // R18
        cnt_next = (cnt_reg == PER_LAST) ? '0 : cnt_reg + 1'b1;
        // short gone if the drain is low at the end of an on pulse
        if (!cmd || batt || (cnt_reg == ON_LAST && !sense)) begin
          st_next  = pfd_pkg::PFD_CH_RUN;
          cnt_next = '0;
        end
      end
      default: st_next = pfd_pkg::PFD_CH_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg  <= pfd_pkg::PFD_CH_RUN; // R22
      cnt_reg <= '0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // drain low while off means open load
  assign short_flt = (st_reg != pfd_pkg::PFD_CH_RUN);
  assign open_flt  = (st_reg == pfd_pkg::PFD_CH_RUN) & ~gate & ~sense; // R15

  a_deglitch_len: assert property ( // R19
    @(posedge clk) disable iff (!rst_n)
    $rose(short_flt) |-> $past(cnt_reg) == DEG_LAST)
    else $error("short flagged before deglitch count");
  a_short_shut: assert property ( // R17
    @(posedge clk) disable iff (!rst_n)
    (!PWM_MODE && st_reg == pfd_pkg::PFD_CH_RUN && gate && sense
     && cnt_reg == DEG_LAST) |=> !gate && short_flt)
    else $error("shorted channel not shut off");
  a_pwm_off_phase: assert property ( // R18
    @(posedge clk) disable iff (!rst_n)
    (st_reg == pfd_pkg::PFD_CH_PWM && cnt_reg >= ON_CNT) |-> !gate)
    else $error("gate on during pwm off phase");
  c_pwm_entry: cover property (
    @(posedge clk) disable iff (!rst_n) st_reg == pfd_pkg::PFD_CH_PWM);
endmodule // pfd_chan
`default_nettype wire

// ### rtl/pfd_shift.sv
// serial clock domain: fault word out, control bits in
`default_nettype none
module pfd_shift (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic rst_n,
  input  wire logic serial_in,
  output logic      serial_out,
  pfd_link_if.link  lnk
);
  logic       arst_n;
  logic       started_reg;
  logic       started_next;
  logic [3:0] sh_reg;
  logic [3:0] sh_next;

  // frame flag ends with the frame's own select, no sclk edge needed
  assign arst_n = rst_n & ~cs_n;

  // ----------------------------------------------------------------
  // shift path
  // ----------------------------------------------------------------
  always_comb begin
    started_next = 1'b1;
    // first edge loads the frozen fault word under the new bit
    if (started_reg) begin
      sh_next = {sh_reg[2:0], serial_in}; // R2
    end else begin
      sh_next = {lnk.fault_word[2:0], serial_in}; // R5
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= started_next;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= 4'h0;
    end else begin
      sh_reg <= sh_next;
    end
  end

  // after four edges the first input bit leaves for the next device
  assign serial_out     = started_reg ? sh_reg[3] : lnk.fault_word[3]; // R11
  assign lnk.shift_word = sh_reg;

  a_shift_order: assert property ( // R5
    @(posedge sclk) disable iff (!arst_n)
    started_reg |=> sh_reg[0] == $past(serial_in) && sh_reg[3] == $past(sh_reg[2]))
    else $error("shift order broken");
endmodule // pfd_shift
`default_nettype wire

// ### rtl/pfd_top.sv
// top of the four channel predriver control and fault logic
`default_nettype none
`include "pfd_defines.svh"
// Summary of operation
// R1: select fall enables output, freezes faults
// R2: sample serial input on serial clock rise
// R3: host shifts four bits per device
// R4: control bit one drives channel on
// R5: fault bits shift out while input shifts
// R6: fault word bit n is channel n
// R7: fault bits follow live detectors when idle
// R8: faults after select fall are not captured
// R9: host raises select after all bits
// R10: select rise latches control, clears faults
// R11: input bits follow own faults on output
// R12: direct inputs drive channels without serial
// R13: channel on is serial OR direct
// R14: direct users still read faults serially
// R15: drain means short when on, open off
// R16: reference select picks internal or external
// R17: shutdown variant turns shorted channel off
// R18: pwm variant pulses shorted channel low duty
// R19: shorts count only after deglitch time
// R20: battery fault disables all, raises alert
// R21: battery fault hidden, load faults suppressed
// R22: reset clears state, gates off
// R23: alert is active low open drain
// R24: deglitch and pwm times are cycle counts
// R25: comparator and battery inputs are synchronised
// R26: host holds serial clock low around select
module pfd_top #(
  parameter pfd_pkg::pfd_variant_t VARIANT = pfd_pkg::PFD_SHUTDOWN,
  parameter int unsigned           DEG_CYC = `PFD_DEGLITCH_CYC,
  parameter int unsigned           PWM_ON  = `PFD_PWM_ON_CYC,
  parameter int unsigned           PWM_PER = `PFD_PWM_PER_CYC
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                serial_in,
  output logic                     serial_out,
  output logic                     serial_out_oe,
  input  wire logic [`PFD_NCH-1:0] direct_ctrl,
  input  wire logic [`PFD_NCH-1:0] load_sense,
  output logic      [`PFD_NCH-1:0] fet_drive,
  input  wire logic                ext_ref_select,
  output logic                     ext_ref_active,
  input  wire logic                batt_over,
  input  wire logic                batt_under,
  output logic                     fault_alert_n,
  output logic                     fault_alert_n_oe
);
  localparam int unsigned NCH = `PFD_NCH;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1_reg;
  logic rst_sync_n_reg;

  // assert at once, release on the clock to avoid a ragged start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1_reg     <= 1'b0; // R22
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_q1_reg     <= 1'b1;
      rst_sync_n_reg <= rst_q1_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`PFD_SYNC_W-1:0] sync_raw;
  logic [`PFD_SYNC_W-1:0] sync1_reg;
  logic [`PFD_SYNC_W-1:0] sync2_reg;
  logic                   cs_s;
  logic                   ref_s;
  logic                   batt_s;
  logic [NCH-1:0]         dir_s;
  logic [NCH-1:0]         sense_s;

  assign sync_raw = {cs_n, ext_ref_select, batt_over, batt_under, direct_ctrl, load_sense};

  // only the second stage is read by any logic
  always_ff @(posedge clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      sync1_reg <= `PFD_SYNC_RST;
      sync2_reg <= `PFD_SYNC_RST;
    end else begin
      sync1_reg <= sync_raw; // R25
      sync2_reg <= sync1_reg;
    end
  end

  // unpack the synchronised pins
  assign cs_s    = sync2_reg[`PFD_SY_CS];
  assign ref_s   = sync2_reg[`PFD_SY_REF];
  assign batt_s  = sync2_reg[`PFD_SY_OV] | sync2_reg[`PFD_SY_UV];
  assign dir_s   = sync2_reg[`PFD_SY_DIR +: NCH];
  assign sense_s = sync2_reg[`PFD_SY_SNS +: NCH];

  // ----------------------------------------------------------------
  // serial clock domain
  // ----------------------------------------------------------------
  pfd_link_if lnk ();

  pfd_shift u_shift (
    .sclk       (sclk),
    .cs_n       (cs_n),
    .rst_n      (rst_sync_n_reg),
    .serial_in  (serial_in),
    .serial_out (serial_out),
    .lnk        (lnk.link)
  );

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [NCH-1:0] ctrl_reg;
  logic [NCH-1:0] ctrl_next;
  logic [NCH-1:0] cmd;
  logic [NCH-1:0] ch_gate;
  logic [NCH-1:0] ch_short;
  logic [NCH-1:0] ch_open;
  logic [NCH-1:0] live;

  // either path can turn a channel on
  assign cmd = ctrl_reg | dir_s; // R13

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      pfd_chan #(
        .DEG_CYC  (DEG_CYC),
        .PWM_ON   (PWM_ON),
        .PWM_PER  (PWM_PER),
        .PWM_MODE (VARIANT == pfd_pkg::PFD_PWM)
      ) u_chan (
        .clk       (clk),
        .rst_n     (rst_sync_n_reg),
        .cmd       (cmd[gi]),
        .sense     (sense_s[gi]),
        .batt      (batt_s),
        .gate      (ch_gate[gi]),
        .short_flt (ch_short[gi]),
        .open_flt  (ch_open[gi])
      );
    end
  endgenerate

  // one combined load fault bit per channel, hidden under battery fault
  function automatic logic [NCH-1:0] load_fault(
    input logic [NCH-1:0] sh,
    input logic [NCH-1:0] op,
    input logic           bt
  );
    load_fault = bt ? '0 : (sh | op); // R21
  endfunction

  assign live = load_fault(ch_short, ch_open, batt_s); // R6

  // ----------------------------------------------------------------
  // frame control, fault register, outputs
  // ----------------------------------------------------------------
  logic           cs_d_reg;
  logic           cs_d_next;
  logic           cs_rise;
  logic           cs_fall;
  logic           oe_reg;
  logic           oe_next;
  logic [NCH-1:0] fault_reg;
  logic [NCH-1:0] fault_next;
  logic           alert_reg;
  logic           alert_next;
  logic [NCH-1:0] gate_reg;
  logic [NCH-1:0] gate_next;
  logic           refsel_reg;
  logic           refsel_next;

  assign cs_rise = cs_s & ~cs_d_reg;
  assign cs_fall = ~cs_s & cs_d_reg;

  // next values of the core registers
  always_comb begin
    cs_d_next   = cs_s;
    oe_next     = ~cs_s; // R1
    ctrl_next   = ctrl_reg;
    fault_next  = live; // R7
    alert_next  = batt_s | (|load_fault(ch_short, ch_open, batt_s)); // R23
    gate_next   = ch_gate; // R12
    refsel_next = ref_s; // R16
    // shift word is quiet here: sclk held low once select is high
    if (cs_rise) begin
      ctrl_next  = lnk.shift_word; // R10
      fault_next = `PFD_FAULT_RST; // R10
    end else if (!cs_s) begin
      fault_next = fault_reg; // R8
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      cs_d_reg   <= 1'b1;
      oe_reg     <= 1'b0;
      ctrl_reg   <= `PFD_CTRL_RST; // R22
      fault_reg  <= `PFD_FAULT_RST;
      alert_reg  <= 1'b0;
      gate_reg   <= '0; // R22
      refsel_reg <= 1'b0;
    end else begin
      cs_d_reg   <= cs_d_next;
      oe_reg     <= oe_next;
      ctrl_reg   <= ctrl_next; // R4
      fault_reg  <= fault_next;
      alert_reg  <= alert_next;
      gate_reg   <= gate_next;
      refsel_reg <= refsel_next;
    end
  end

  // frozen during a frame, so the serial clock may read it
  assign lnk.fault_word   = fault_reg; // R1
  assign serial_out_oe    = oe_reg;
  assign fet_drive        = gate_reg;
  assign ext_ref_active   = refsel_reg;
  // open drain: only ever pulls the shared line low
  assign fault_alert_n    = 1'b0;
  assign fault_alert_n_oe = alert_reg; // R23

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n_reg);

  // lockout drops every gate one cycle after the battery fault
  a_batt_gates_off: assert property ( // R20
    batt_s |=> fet_drive == '0)
    else $error("gate on during battery fault");

  // battery fault alone is enough to pull the alert line
  a_batt_alert: assert property ( // R20
    batt_s |=> fault_alert_n_oe)
    else $error("no alert during battery fault");

  // idle register stays empty while the battery is out of range
  a_batt_hidden: assert property ( // R21
    (batt_s && cs_s && cs_d_reg) |=> fault_reg == '0)
    else $error("load fault reported under battery fault");

  // shift word is quiet at the rise, so one sample is safe
  a_rise_latch: assert property ( // R10
    cs_rise |=> ctrl_reg == $past(lnk.shift_word))
    else $error("control bits not latched at select rise");

  // re-arm starts from an empty register
  a_rise_clear: assert property ( // R10
    cs_rise |=> fault_reg == '0)
    else $error("fault register not cleared at select rise");

  // late faults must not reach the frozen snapshot
  a_frame_freeze: assert property ( // R8
    (!cs_s ##1 !cs_s) |-> $stable(fault_reg))
    else $error("fault register moved during frame");

  // output driver comes up right after the synchronised fall
  a_fall_drive: assert property ( // R1
    cs_fall |=> serial_out_oe ##1 serial_out_oe)
    else $error("serial output not enabled after select fall");

  // outside a frame the register is one cycle behind the detectors
  a_idle_track: assert property ( // R7
    (cs_s && cs_d_reg) |=> fault_reg == $past(live))
    else $error("fault register does not track detectors");

  // direct input needs neither select nor serial clock
  a_direct_on: assert property ( // R12
    (dir_s[0] && !batt_s && !ch_short[0]) |=> fet_drive[0])
    else $error("direct input did not turn channel on");

  // healthy channels simply register the combined command
  a_or_paths: assert property ( // R13
    (!batt_s && ch_short == '0) |=> fet_drive == $past(cmd))
    else $error("gate is not serial or direct command");

  // alert is not frozen by a frame, unlike the register
  a_alert_live: assert property ( // R23
    (live != '0) |=> ##1 fault_alert_n_oe || $past(live) == '0)
    else $error("alert missing for a live load fault");

  // ----------------------------------------------------------------
  // output relations
  // ----------------------------------------------------------------
  // serial output released between frames
  a_idle_oe_off: assert property ( // R10
    (cs_s && cs_d_reg) |=> !serial_out_oe)
    else $error("serial output driven outside a frame");

  // output stays enabled while the frame lasts
  a_frame_oe_on: assert property ( // R1
    (!cs_s && !cs_d_reg) |-> serial_out_oe)
    else $error("serial output not driven inside a frame");

  // snapshot is the value held just before the fall
  a_fall_capture: assert property ( // R1
    cs_fall |=> fault_reg == $past(fault_reg))
    else $error("fault snapshot changed at select fall");

  // control latch only moves at a select rise
  a_latch_hold: assert property ( // R4
    !cs_rise |=> ctrl_reg == $past(ctrl_reg))
    else $error("control latch moved outside select rise");

  // strap copied one stage after its synchroniser
  a_ref_follow: assert property ( // R16
    (ext_ref_active != ref_s) |=> ext_ref_active == $past(ref_s))
    else $error("reference select not followed");

  // no load fault leaks out under a battery fault
  a_batt_live: assert property ( // R21
    batt_s |-> live == '0)
    else $error("load fault live under battery fault");

  // an open load raises the alert on the next cycle
  a_open_alert: assert property ( // R15
    (ch_open != '0 && !batt_s) |=> fault_alert_n_oe)
    else $error("open load gave no alert");

  // alert drops once nothing is wrong
  a_alert_quiet: assert property ( // R23
    (!batt_s && live == '0) |=> !fault_alert_n_oe)
    else $error("alert held with no fault");

  // shorted channels land in their own bit of the idle register
  a_short_bit: assert property ( // R6
    (ch_short != '0 && !batt_s && cs_s && cs_d_reg)
    |=> (fault_reg & $past(ch_short)) == $past(ch_short))
    else $error("short missing from fault register");

  // a shut channel stays dark in the shutdown variant
  a_shut_dark: assert property ( // R17
    (VARIANT == pfd_pkg::PFD_SHUTDOWN && ch_short != '0)
    |=> (fet_drive & $past(ch_short)) == '0)
    else $error("shut channel still driven");

  c_frame: cover property (cs_fall ##[1:400] cs_rise);
  c_fault_read: cover property (cs_fall && fault_reg != '0);
  c_short: cover property ($rose(ch_short[0]));
  c_batt: cover property ($rose(batt_s) ##[1:100] $fell(batt_s));
endmodule // pfd_top
`default_nettype wire

// ### test/pfd_host_model.sv
// host model: drives select, serial clock and data, collects the reply
`default_nettype none
module pfd_host_model (
  output logic     cs_n,
  output logic     sclk,
  output logic     serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------
  // idle levels
  // ------------------------------
  // select parked high, clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end

  // ------------------------------
  // frame
  // ------------------------------
  // highest bit goes first; the 12 ns clock runs only inside the frame
  task automatic frame(input logic [7:0] din, input int nb, output logic [7:0] dout);
    dout = 8'h00;
    #3;                    // off the core clock edge
    cs_n = 1'b0;
    #200;                  // lead time, sclk low at the fall
    for (int k = nb - 1; k >= 0; k--) begin
      serial_in = din[k];
      #6;
      dout[k] = serial_out;
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #12;
    cs_n = 1'b1;           // raised once every bit is
    serial_in = 1'b0;      // released input sits at its pull-down
    #200;                  // gap before the next frame
  endtask
endmodule // pfd_host_model
`default_nettype wire

// ### test/pfd_top_bench.sv
// self-checking bench of the predriver control and fault logic
`default_nettype none
module pfd_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // long deglitch so the transients of a control change never count
  localparam int DEG = 24;

  logic       clk, rstn, cs_n, sclk, serial_in, serial_out, serial_out_oe;
  logic       ext_ref_select, ext_ref_active, batt_over, batt_under;
  logic       fault_alert_n, fault_alert_n_oe;
  logic [3:0] direct_ctrl, load_sense, fet_drive, pwm_drive;
  logic [3:0] c, d, nw, cur, f;
  logic [7:0] d8;
  int         n_errors, check_count, n, ch;

  pfd_top #(.VARIANT(pfd_pkg::PFD_SHUTDOWN), .DEG_CYC(DEG), .PWM_ON(4), .PWM_PER(16)) dut_u (
    .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .direct_ctrl(direct_ctrl),
    .load_sense(load_sense), .fet_drive(fet_drive), .ext_ref_select(ext_ref_select),
    .ext_ref_active(ext_ref_active), .batt_over(batt_over), .batt_under(batt_under),
    .fault_alert_n(fault_alert_n), .fault_alert_n_oe(fault_alert_n_oe));

  // same stimulus into the pwm variant; only its gate drive is watched
  pfd_top #(.VARIANT(pfd_pkg::PFD_PWM), .DEG_CYC(DEG), .PWM_ON(4), .PWM_PER(16)) dut_pwm_u (
    .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(), .serial_out_oe(), .direct_ctrl(direct_ctrl),
    .load_sense(load_sense), .fet_drive(pwm_drive), .ext_ref_select(ext_ref_select),
    .ext_ref_active(), .batt_over(batt_over), .batt_under(batt_under),
    .fault_alert_n(), .fault_alert_n_oe());

  pfd_host_model host_u (
    .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in), .serial_out(serial_out));

  // ------------------------------
  // clock and helpers
  // ------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // either path alone turns a channel on
  function automatic logic [3:0] exp_gate(input logic [3:0] sc, input logic [3:0] dc);
    return sc | dc;
  endfunction

  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // settle just after the edge so registered outputs have landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic run_frame(input logic [3:0] sc, output logic [3:0] fw);
    logic [7:0] r;
    host_u.frame({4'h0, sc}, 4, r);
    fw = r[3:0];
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    void'($urandom(75829));
    rstn = 1'b0;
    direct_ctrl = 4'h0;
    load_sense = 4'hf;
    ext_ref_select = 1'b0;
    batt_over = 1'b0;
    batt_under = 1'b0;
    cur = 4'h0;
    tick(5);
    check(fet_drive, 4'h0, "rst gate");
    check({serial_out_oe, fault_alert_n_oe, 2'b00}, 4'h0, "rst oe");
    rstn <= 1'b1;
    tick(6);
    // random control mix; sense is the inverse of the gate so no fault is real
    for (int i = 0; i < 8; i++) begin
      c = 4'($urandom());
      d = 4'($urandom());
      if (i == 0) begin
        c = 4'hf;
        d = 4'h0;
      end
      if (i == 1) begin
        c = 4'h0;
        d = 4'hf;
      end
      nw = exp_gate(c, d);
      @(posedge clk);
      direct_ctrl <= d;
      load_sense <= ~cur | (cur ^ nw);
      run_frame(c, f);
      check(f, 4'h0, "fault word");
      check({3'h0, serial_out_oe}, 4'h0, "oe after");
      @(posedge clk);
      load_sense <= ~nw;
      tick(6);
      check(fet_drive, nw, "gate");
      check({3'h0, fault_alert_n_oe}, 4'h0, "alert idle");
      cur = nw;
    end
    // all off, then an open load that appears after the freeze
    @(posedge clk);
    direct_ctrl <= 4'h0;
    load_sense <= 4'hf;
    run_frame(4'h0, f);
    tick(6);
    ch = int'($urandom() % 4);
    fork
      run_frame(4'h0, f);
      begin
        tick(5);
        check({3'h0, serial_out_oe}, 4'h1, "oe in frame");
        load_sense <= ~(4'h1 << ch);
      end
    join
    check(f, 4'h0, "late fault");
    tick(4);
    check({fault_alert_n_oe, fault_alert_n, 2'b00}, 4'h8, "alert");
    run_frame(4'h0, f);
    check(f, 4'h1 << ch, "open bit");
    @(posedge clk);
    load_sense <= 4'hf;
    tick(6);
    run_frame(4'h0, f);
    run_frame(4'h0, f);
    check(f, 4'h0, "cleared");
    // two chained devices: own faults then the passed-through bits
    host_u.frame(8'ha5, 8, d8);
    check(d8[7:4], 4'h0, "chain flt");
    check(d8[3:0], 4'ha, "chain pass");
    @(posedge clk);
    load_sense <= 4'ha;
    tick(6);
    check(fet_drive, 4'h5, "last four");
    // short shorter than the deglitch is ignored
    @(posedge clk);
    load_sense <= 4'hb;
    tick(DEG - 6);
    load_sense <= 4'ha;
    tick(6);
    check({fet_drive[0], fault_alert_n_oe, 2'b00}, 4'h8, "glitch");
    // lasting short shuts the channel after the deglitch count
    load_sense <= 4'hb;
    n = 0;
    while (fet_drive[0] !== 1'b0 && n < DEG + 12) begin
      tick(1);
      n++;
    end
    if (n >= DEG + 12) begin
      n_errors++;
      complete_run();
    end
    check({2'b00, n >= DEG, n <= DEG + 8}, 4'h3, "deglitch");
    tick(2);
    check({3'h0, fault_alert_n_oe}, 4'h1, "short alert");
    // pwm variant pulses the shorted channel four in every sixteen
    n = 0;
    repeat (32) begin
      tick(1);
      n += int'(pwm_drive[0]);
    end
    check({3'h0, n == 8}, 4'h1, "pwm duty");
    run_frame(4'h5, f);
    check(f, 4'h1, "short bit");
    check(fet_drive, 4'h4, "stays off");
    run_frame(4'h4, f);
    tick(6);
    check({3'h0, fault_alert_n_oe}, 4'h0, "cmd drop");
    check(pwm_drive, 4'h4, "pwm exit");
    // battery over then under voltage lockout
    @(posedge clk);
    direct_ctrl <= 4'h3;
    load_sense <= 4'hb;
    tick(5);
    load_sense <= 4'h8;
    tick(6);
    for (int b = 0; b < 2; b++) begin
      check(fet_drive, 4'h7, "pre batt");
      batt_over <= (b == 0);
      batt_under <= (b == 1);
      tick(6);
      check({fet_drive[2:0], fault_alert_n_oe}, 4'h1, "lockout");
      run_frame(4'h4, f);
      check(f, 4'h0, "batt hidden");
      batt_over <= 1'b0;
      batt_under <= 1'b0;
      tick(6);
      check({fet_drive[2:0], fault_alert_n_oe}, 4'he, "resume");
    end
    // static reference strap both ways
    for (int v = 1; v >= 0; v--) begin
      ext_ref_select <= v[0];
      tick(5);
      check({3'h0, ext_ref_active}, {3'h0, v[0]}, "ref sel");
    end
    // second reset mid-run clears the serial latch
    rstn <= 1'b0;
    tick(1);
    check(fet_drive, 4'h0, "reset gate");
    rstn <= 1'b1;
    tick(6);
    check(fet_drive, 4'h3, "latch clr");
    complete_run();
  end
endmodule // pfd_top_bench
`default_nettype wire
